// ===== logic/ctt_pkg.sv
`default_nettype none
package ctt_pkg;
    localparam logic [15:0] CTT_ALL_CLUSTERS = 16'hFFFF;
    localparam logic [15:0] CTT_MAX_COUNT = 16'h0200;
    localparam logic [7:0] CTT_KIND_VSC = 8'h01;
    localparam logic [7:0] CTT_KIND_DATA = 8'h02;
    localparam logic [7:0] CTT_KIND_CNUM = 8'h03;
    localparam int CTT_KINDS = 3;
    localparam int CTT_CLK_HZ = 100000000;
    localparam int CTT_SEC_NS = 1000000000;
    localparam int CTT_CLK_PERIOD_NS = CTT_SEC_NS / CTT_CLK_HZ;
    localparam int CTT_TICKS_PER_SEC = CTT_SEC_NS / CTT_CLK_PERIOD_NS;
    localparam logic [7:0] CTT_PEER_TIMEOUT_S = 8'h05;

    typedef enum logic [3:0] {
        CTT_RES_OK,
        CTT_RES_ILLEGAL,
        CTT_RES_ABSENT_CLUSTER,
        CTT_RES_ROUTE_FAULT,
        CTT_RES_FAR_TIMEOUT,
        CTT_RES_PEER_UNAVAILABLE,
        CTT_RES_PEER_RECEIVER_FULL,
        CTT_RES_PEER_OVERSIZE,
        CTT_RES_GENERAL_FAILURE
    } ctt_result_type;

    typedef struct packed {
        logic [15:0] cluster;
        logic [7:0] kind;
        logic [15:0] count;
        logic [15:0] word;
    } ctt_xfer_type;

    typedef enum logic [1:0] {SND_IDLE, SND_SCAN, SND_WAIT, SND_DONE} ctt_snd_state_type;
    typedef enum logic [1:0] {RCV_IDLE, RCV_WAIT, RCV_DONE} ctt_rcv_state_type;
endpackage
`default_nettype wire

// ===== logic/ctt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ctt_timer #(
    parameter int TICKS = 100000000,
    parameter int SEC_W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic [SEC_W-1:0] limit,
    // Status
    output logic expired
);
    localparam int TW = (TICKS > 1) ? $clog2(TICKS) : 1;

    typedef struct packed {
        logic [TW-1:0] tick;
        logic [SEC_W-1:0] sec;
        logic expired;
    } ctt_tmr_state_type;

    ctt_tmr_state_type s_reg;
    ctt_tmr_state_type s_next;

    // Counting restarts whenever run drops, so a stale wait never leaks into the next
    always_comb begin
        s_next = s_reg;
        if (!run) begin
            s_next = '0;
        end else if (!s_reg.expired) begin
            if (s_reg.sec == limit) begin
                s_next.expired = 1'b1;
            end else if (s_reg.tick == TW'(TICKS - 1)) begin
                s_next.tick = '0;
                s_next.sec = s_reg.sec + 1'b1;
            end else begin
                s_next.tick = s_reg.tick + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign expired = s_reg.expired;
endmodule
`default_nettype wire

// ===== logic/ctt_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - All-clusters send reaches every other node
// - Other cluster value: at most one delivery, none for an absent cluster
// - VSC or broadcast: ok after all complete
// - Unicast data returns ok, reason, peer result
// - Device picks one adapter in cluster
// - Cluster-id kind sends own cluster number
// - Peer delivery forwarded to registered receiver
// - VSC delivery ok after host completes
// - Failed VSC host delivery: sticky fault
// - VSC host timeout: ok plus fault
// - Unicast data delivery reflects host outcome
// - Results drawn from the fixed result set
// - One registered receiver per kind
// - Host timeout uses registered seconds
module ctt_top import ctt_pkg::*; #(
    parameter int NODES = 8,
    parameter int TICKS_PER_SEC = CTT_TICKS_PER_SEC,
    parameter logic [7:0] PEER_TIMEOUT_S = CTT_PEER_TIMEOUT_S
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    // Node table
    input wire logic [15:0] own_cluster,
    input wire logic [NODES-1:0] node_up,
    input wire logic [NODES-1:0][15:0] node_cluster,
    // Host send request
    input wire logic hs_valid,
    input wire ctt_xfer_type hs_req,
    output logic hs_ready,
    output logic hs_done,
    output ctt_result_type hs_result,
    // Outgoing peer delivery
    output logic po_valid,
    output logic [$clog2(NODES)-1:0] po_node,
    output ctt_xfer_type po_req,
    input wire logic po_done,
    input wire ctt_result_type po_result,
    // Incoming peer delivery
    input wire logic pi_valid,
    input wire ctt_xfer_type pi_req,
    output logic pi_ready,
    output logic pi_done,
    output ctt_result_type pi_result,
    // Host delivery
    output logic hd_valid,
    output logic [15:0] hd_service,
    output ctt_xfer_type hd_req,
    input wire logic hd_done,
    input wire ctt_result_type hd_result,
    // Receiver registration
    input wire logic reg_valid,
    input wire logic reg_connect,
    input wire logic [7:0] reg_kind,
    input wire logic [15:0] reg_service,
    input wire logic [7:0] reg_timeout_s,
    output logic reg_done,
    output logic reg_ok,
    // Fault status
    output logic fault_status
);
    localparam int NW = $clog2(NODES);
    localparam logic [NW-1:0] LAST_NODE = NW'(NODES - 1);

    typedef struct packed {
        ctt_snd_state_type snd;
        ctt_rcv_state_type rcv;
        ctt_xfer_type sreq;
        ctt_result_type sres;
        logic [NW-1:0] idx;
        logic any;
        ctt_xfer_type rreq;
        ctt_result_type rres;
        logic [7:0] rtmo;
        logic [CTT_KINDS-1:0] reg_on;
        logic [CTT_KINDS-1:0][15:0] reg_svc;
        logic [CTT_KINDS-1:0][7:0] reg_tmo;
        logic hs_ready;
        logic hs_done;
        ctt_result_type hs_result;
        logic po_valid;
        logic [NW-1:0] po_node;
        ctt_xfer_type po_req;
        logic pi_ready;
        logic pi_done;
        ctt_result_type pi_result;
        logic hd_valid;
        logic [15:0] hd_service;
        ctt_xfer_type hd_req;
        logic reg_done;
        logic reg_ok;
        logic fault;
    } ctt_state_type;

    ctt_state_type s_reg;
    ctt_state_type s_next;
    logic peer_expired;
    logic host_expired;

    function automatic logic kind_ok(input logic [7:0] k);
        kind_ok = (k == CTT_KIND_VSC) || (k == CTT_KIND_DATA) || (k == CTT_KIND_CNUM);
    endfunction

    function automatic logic [1:0] kind_idx(input logic [7:0] k);
        kind_idx = 2'(k - CTT_KIND_VSC);
    endfunction

    // Peer waits use a fixed timeout; host waits use what the receiver registered
    ctt_timer #(.TICKS(TICKS_PER_SEC), .SEC_W(8)) u_peer_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .run(s_reg.snd == SND_WAIT),
        .limit(PEER_TIMEOUT_S),
        .expired(peer_expired)
    );

    ctt_timer #(.TICKS(TICKS_PER_SEC), .SEC_W(8)) u_host_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .run(s_reg.rcv == RCV_WAIT),
        .limit(s_reg.rtmo),
        .expired(host_expired)
    );

    always_comb begin
        logic bcast;
        logic elig;
        logic [1:0] k;
        bcast = 1'b0;
        elig = 1'b0;
        k = 2'h0;
        s_next = s_reg;
        s_next.hs_done = 1'b0;
        s_next.po_valid = 1'b0;
        s_next.pi_done = 1'b0;
        s_next.hd_valid = 1'b0;
        s_next.reg_done = 1'b0;
        bcast = (s_reg.sreq.cluster == CTT_ALL_CLUSTERS);

        // Send side: nodes are visited one at a time, trading speed for a single timer
        case (s_reg.snd)
            SND_IDLE: begin
                if (hs_valid && s_reg.hs_ready) begin
                    s_next.sreq = hs_req;
                    s_next.idx = '0;
                    s_next.any = 1'b0;
                    s_next.sres = CTT_RES_OK;
                    s_next.snd = SND_SCAN;
                    if (hs_req.count[0] || (hs_req.count > CTT_MAX_COUNT)) begin
                        s_next.sres = CTT_RES_ILLEGAL;
                        s_next.snd = SND_DONE;
                    end else if (!kind_ok(hs_req.kind)) begin
                        s_next.sres = CTT_RES_ILLEGAL;
                        s_next.snd = SND_DONE;
                    end else if ((hs_req.kind == CTT_KIND_VSC)
                                 && (hs_req.cluster != CTT_ALL_CLUSTERS)) begin
                        s_next.sres = CTT_RES_ILLEGAL;
                        s_next.snd = SND_DONE;
                    end
                    if (hs_req.kind == CTT_KIND_CNUM) begin
                        s_next.sreq.word = own_cluster;
                    end
                end
            end
            SND_SCAN: begin
                // Lowest matching node wins when a cluster holds several adapters
                elig = node_up[s_reg.idx] && (node_cluster[s_reg.idx] != own_cluster)
                       && (bcast || (node_cluster[s_reg.idx] == s_reg.sreq.cluster));
                if (elig) begin
                    s_next.po_valid = 1'b1;
                    s_next.po_node = s_reg.idx;
                    s_next.po_req = s_reg.sreq;
                    s_next.any = 1'b1;
                    s_next.snd = SND_WAIT;
                end else if (s_reg.idx == LAST_NODE) begin
                    s_next.snd = SND_DONE;
                    if (!bcast && !s_reg.any) begin
                        s_next.sres = (s_reg.sreq.cluster == own_cluster) ?
                                      CTT_RES_ROUTE_FAULT : CTT_RES_ABSENT_CLUSTER;
                    end
                end else begin
                    s_next.idx = s_reg.idx + 1'b1;
                end
            end
            SND_WAIT: begin
                if (po_done || peer_expired) begin
                    if (!bcast) begin
                        s_next.sres = po_done ? po_result : CTT_RES_FAR_TIMEOUT;
                        s_next.snd = SND_DONE;
                    end else if (s_reg.idx == LAST_NODE) begin
                        s_next.snd = SND_DONE;
                    end else begin
                        s_next.idx = s_reg.idx + 1'b1;
                        s_next.snd = SND_SCAN;
                    end
                end
            end
            SND_DONE: begin
                s_next.hs_done = 1'b1;
                s_next.hs_result = s_reg.sres;
                s_next.snd = SND_IDLE;
            end
            default: s_next.snd = SND_IDLE;
        endcase

        // Receive side
        case (s_reg.rcv)
            RCV_IDLE: begin
                if (pi_valid && s_reg.pi_ready) begin
                    k = kind_idx(pi_req.kind);
                    s_next.rreq = pi_req;
                    s_next.rcv = RCV_DONE;
                    if (!kind_ok(pi_req.kind) || pi_req.count[0]
                        || (pi_req.count > CTT_MAX_COUNT)) begin
                        s_next.rres = CTT_RES_ILLEGAL;
                    end else if (!s_reg.reg_on[k]) begin
                        s_next.rres = (pi_req.kind == CTT_KIND_VSC) ?
                                      CTT_RES_OK : CTT_RES_PEER_UNAVAILABLE;
                    end else begin
                        s_next.hd_valid = 1'b1;
                        s_next.hd_req = pi_req;
                        s_next.hd_service = s_reg.reg_svc[k];
                        s_next.rtmo = s_reg.reg_tmo[k];
                        s_next.rcv = RCV_WAIT;
                    end
                end
            end
            RCV_WAIT: begin
                if (hd_done || host_expired) begin
                    s_next.rcv = RCV_DONE;
                    if (s_reg.rreq.kind == CTT_KIND_VSC) begin
                        s_next.rres = CTT_RES_OK;
                        if (!hd_done || (hd_result != CTT_RES_OK)) begin
                            s_next.fault = 1'b1;
                        end
                    end else begin
                        s_next.rres = hd_done ? hd_result : CTT_RES_FAR_TIMEOUT;
                    end
                end
            end
            RCV_DONE: begin
                s_next.pi_done = 1'b1;
                s_next.pi_result = s_reg.rres;
                s_next.rcv = RCV_IDLE;
            end
            default: s_next.rcv = RCV_IDLE;
        endcase

        // Registration; a second service for a taken kind is refused
        if (reg_valid) begin
            k = kind_idx(reg_kind);
            s_next.reg_done = 1'b1;
            s_next.reg_ok = 1'b0;
            if (kind_ok(reg_kind)) begin
                if (reg_connect) begin
                    if (!s_reg.reg_on[k] || (s_reg.reg_svc[k] == reg_service)) begin
                        s_next.reg_on[k] = 1'b1;
                        s_next.reg_svc[k] = reg_service;
                        s_next.reg_tmo[k] = reg_timeout_s;
                        s_next.reg_ok = 1'b1;
                    end
                end else if (s_reg.reg_on[k] && (s_reg.reg_svc[k] == reg_service)) begin
                    s_next.reg_on[k] = 1'b0;
                    s_next.reg_ok = 1'b1;
                end
            end
        end

        s_next.hs_ready = (s_next.snd == SND_IDLE);
        s_next.pi_ready = (s_next.rcv == RCV_IDLE);
    end

    // Fault has no clear path other than reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign hs_ready = s_reg.hs_ready;
    assign hs_done = s_reg.hs_done;
    assign hs_result = s_reg.hs_result;
    assign po_valid = s_reg.po_valid;
    assign po_node = s_reg.po_node;
    assign po_req = s_reg.po_req;
    assign pi_ready = s_reg.pi_ready;
    assign pi_done = s_reg.pi_done;
    assign pi_result = s_reg.pi_result;
    assign hd_valid = s_reg.hd_valid;
    assign hd_service = s_reg.hd_service;
    assign hd_req = s_reg.hd_req;
    assign reg_done = s_reg.reg_done;
    assign reg_ok = s_reg.reg_ok;
    assign fault_status = s_reg.fault;
endmodule
`default_nettype wire

// ===== verif/ctt_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ctt_top_asserts import ctt_pkg::*; #(
    parameter int NODES = 8
) (
    // Clock and node table
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [15:0] own_cluster,
    input wire logic [NODES-1:0] node_up,
    input wire logic [NODES-1:0][15:0] node_cluster,
    // Send side
    input wire logic hs_valid,
    input wire ctt_xfer_type hs_req,
    input wire logic hs_ready,
    input wire logic hs_done,
    input wire ctt_result_type hs_result,
    input wire logic po_valid,
    input wire logic [$clog2(NODES)-1:0] po_node,
    input wire ctt_xfer_type po_req,
    // Receive side
    input wire logic pi_valid,
    input wire ctt_xfer_type pi_req,
    input wire logic pi_ready,
    input wire logic pi_done,
    input wire ctt_result_type pi_result,
    input wire logic fault_status
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic hs_take;
    logic pi_take;
    logic bc_legal_reg;
    logic pi_vsc_reg;
    assign hs_take = hs_valid && hs_ready && ce;
    assign pi_take = pi_valid && pi_ready && ce;
    // Broadcast legality and VSC kind are latched at take so the answer can be judged cycles later
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bc_legal_reg <= 1'b0;
            pi_vsc_reg <= 1'b0;
        end else begin
            if (hs_take)
                bc_legal_reg <= hs_req.cluster == CTT_ALL_CLUSTERS && !hs_req.count[0]
                    && hs_req.count <= CTT_MAX_COUNT
                    && hs_req.kind inside {CTT_KIND_VSC, CTT_KIND_DATA, CTT_KIND_CNUM};
            if (pi_take)
                pi_vsc_reg <= pi_req.kind == CTT_KIND_VSC;
        end
    end
    a_odd_refused: assert property (hs_take && hs_req.count[0] |->
        ##[1:3] (hs_done && hs_result == CTT_RES_ILLEGAL)) else $error("odd count not refused");
    a_big_refused: assert property (hs_take && hs_req.count > CTT_MAX_COUNT |->
        ##[1:3] (hs_done && hs_result == CTT_RES_ILLEGAL)) else $error("big count not refused");
    a_refused_silent: assert property (hs_take && hs_req.count[0] |=> !po_valid [*3])
        else $error("delivery issued for refused send");
    a_bcast_ok: assert property (hs_done && bc_legal_reg |-> hs_result == CTT_RES_OK)
        else $error("broadcast send not ok");
    a_bcast_other: assert property (po_valid && po_req.cluster == CTT_ALL_CLUSTERS |->
        node_up[po_node] && node_cluster[po_node] != own_cluster) else $error("bad fan-out node");
    a_uni_target: assert property (po_valid && po_req.cluster != CTT_ALL_CLUSTERS |->
        node_up[po_node] && node_cluster[po_node] == po_req.cluster) else $error("bad target node");
    a_cnum_word: assert property (po_valid && po_req.kind == CTT_KIND_CNUM |->
        po_req.word == own_cluster) else $error("cluster id word wrong");
    a_vsc_rcv_ok: assert property (pi_done && pi_vsc_reg |-> pi_result == CTT_RES_OK)
        else $error("status change delivery not ok");
    a_fault_sticky: assert property (fault_status |=> fault_status)
        else $error("fault status dropped");
endmodule
bind ctt_top ctt_top_asserts #(.NODES(NODES)) u_ctt_chk (.*);
`default_nettype wire

// ===== verif/ctt_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctt_far_model import ctt_pkg::*; (
    // Bench controls
    input wire logic sys_clk,
    input wire logic [3:0] lag,
    input wire logic po_mute,
    input wire logic hd_mute,
    input wire ctt_result_type po_res,
    input wire ctt_result_type hd_res,
    // Peer and host sides
    input wire logic po_valid,
    input wire logic hd_valid,
    output logic po_done,
    output ctt_result_type po_result,
    output logic hd_done,
    output ctt_result_type hd_result
);
    // Result lines scramble outside the done pulse so stale values never pass
    int po_wait = -1;
    int hd_wait = -1;
    initial begin
        po_done = 1'b0;
        hd_done = 1'b0;
        po_result = CTT_RES_OK;
        hd_result = CTT_RES_OK;
    end
    always @(posedge sys_clk) begin
        po_done <= po_wait == 0;
        hd_done <= hd_wait == 0;
        po_result <= po_wait == 0 ? po_res : ctt_result_type'(~po_result);
        hd_result <= hd_wait == 0 ? hd_res : ctt_result_type'(~hd_result);
        po_wait <= po_valid && !po_mute ? int'(lag) : po_wait - int'(po_wait >= 0);
        hd_wait <= hd_valid && !hd_mute ? int'(lag) : hd_wait - int'(hd_wait >= 0);
    end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import ctt_pkg::*;;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic hs_valid = 1'b0;
    logic pi_valid = 1'b0;
    logic reg_valid = 1'b0;
    logic reg_connect = 1'b0;
    logic po_mute = 1'b0;
    logic hd_mute = 1'b0;
    logic [3:0] lag = 4'h0;
    logic [7:0] reg_kind = 8'h00;
    logic [15:0] reg_service = 16'h0000;
    ctt_xfer_type hs_req = '0;
    ctt_xfer_type pi_req = '0;
    ctt_result_type po_res = CTT_RES_OK;
    ctt_result_type hd_res = CTT_RES_OK;
    ctt_xfer_type po_req, hd_req;
    ctt_result_type hs_result, po_result, pi_result, hd_result;
    logic hs_ready, hs_done, po_valid, po_done, pi_ready, pi_done, hd_valid, hd_done;
    logic reg_done, reg_ok, fault_status;
    logic [1:0] po_node, last_node;
    logic [15:0] hd_service, last_word, last_svc, last_hword;
    int err_count = 0;
    int check_count = 0;
    int po_cnt = 0;
    int hd_cnt = 0;
    ctt_top #(.NODES(4), .TICKS_PER_SEC(10)) DUT (.*, .own_cluster(16'h0001),
        .node_up(4'hF), .node_cluster({16'h0003, 16'h0002, 16'h0002, 16'h0001}),
        .reg_timeout_s(8'h01));
    ctt_far_model u_far (.*);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (po_valid) begin
            po_cnt++;
            last_node = po_node;
            last_word = po_req.word;
        end
        if (hd_valid) begin
            hd_cnt++;
            last_svc = hd_service;
            last_hword = hd_req.word;
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_for(ref logic sig, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (sig !== 1'b1 && n < lim);
    endtask
    task automatic send(input logic [15:0] cl, input logic [7:0] kd, input logic [15:0] cnt,
            input ctt_result_type exp, input int n_po);
        po_cnt = 0;
        hs_req <= '{cl, kd, cnt, 16'h5A5A};
        hs_valid <= 1'b1;
        wait_for(hs_ready, 100);
        hs_valid <= 1'b0;
        wait_for(hs_done, 400);
        chk("hs_done", 16'h0001, 16'(hs_done));
        chk("hs_result", 16'(exp), 16'(hs_result));
        chk("po_count", 16'(n_po), 16'(po_cnt));
    endtask
    task automatic rcv(input logic [7:0] kd, input ctt_result_type exp, input int n_hd);
        hd_cnt = 0;
        pi_req <= '{CTT_ALL_CLUSTERS, kd, 16'h0010, 16'hBEEF};
        pi_valid <= 1'b1;
        wait_for(pi_ready, 100);
        pi_valid <= 1'b0;
        wait_for(pi_done, 100);
        chk("pi_result", 16'(exp), 16'(pi_result));
        chk("hd_count", 16'(n_hd), 16'(hd_cnt));
    endtask
    task automatic regi(input logic [7:0] kd, input logic [15:0] svc, input logic ok);
        reg_connect <= 1'b1;
        reg_kind <= kd;
        reg_service <= svc;
        reg_valid <= 1'b1;
        @(posedge sys_clk);
        reg_valid <= 1'b0;
        wait_for(reg_done, 4);
        chk("reg_ok", 16'(ok), 16'(reg_ok));
    endtask
    // A request offered while frozen must not be taken, or a delivery would show
    task automatic t_freeze();
        po_cnt = 0;
        ce <= 1'b0;
        hs_req <= '{16'h0002, CTT_KIND_DATA, 16'h0002, 16'h5A5A};
        hs_valid <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("frozen_po_count", 16'h0000, 16'(po_cnt));
        chk("frozen_hs_done", 16'h0000, 16'(hs_done));
        ce <= 1'b1;
        hs_valid <= 1'b0;
        @(posedge sys_clk);
        send(16'h0002, CTT_KIND_DATA, 16'h0002, CTT_RES_OK, 1);
        $display("test freeze done");
    endtask
    task automatic t_send();
        send(16'hFFFF, CTT_KIND_DATA, 16'h0003, CTT_RES_ILLEGAL, 0);
        send(16'hFFFF, CTT_KIND_DATA, 16'h0202, CTT_RES_ILLEGAL, 0);
        po_res <= CTT_RES_PEER_RECEIVER_FULL;
        send(16'h0002, CTT_KIND_DATA, 16'h0200, CTT_RES_PEER_RECEIVER_FULL, 1);
        chk("po_node", 16'h0001, 16'(last_node));
        send(16'h0007, CTT_KIND_DATA, 16'h0002, CTT_RES_ABSENT_CLUSTER, 0);
        send(16'h0001, CTT_KIND_DATA, 16'h0002, CTT_RES_ROUTE_FAULT, 0);
        po_mute <= 1'b1;
        send(16'h0003, CTT_KIND_DATA, 16'h0002, CTT_RES_FAR_TIMEOUT, 1);
        $display("test send done");
    endtask
    task automatic t_bcast();
        po_res <= CTT_RES_GENERAL_FAILURE;
        lag <= 4'h9;
        send(16'hFFFF, CTT_KIND_DATA, 16'h0002, CTT_RES_OK, 3);
        po_mute <= 1'b0;
        send(16'hFFFF, CTT_KIND_VSC, 16'h0010, CTT_RES_OK, 3);
        lag <= 4'h0;
        send(16'h0003, CTT_KIND_CNUM, 16'h0002, CTT_RES_GENERAL_FAILURE, 1);
        chk("po_word", 16'h0001, last_word);
        $display("test broadcast done");
    endtask
    task automatic t_recv();
        rcv(CTT_KIND_DATA, CTT_RES_PEER_UNAVAILABLE, 0);
        rcv(CTT_KIND_VSC, CTT_RES_OK, 0);
        regi(CTT_KIND_VSC, 16'h0021, 1'b1);
        regi(CTT_KIND_VSC, 16'h0022, 1'b0);
        regi(CTT_KIND_DATA, 16'h0031, 1'b1);
        hd_res <= CTT_RES_PEER_OVERSIZE;
        rcv(CTT_KIND_DATA, CTT_RES_PEER_OVERSIZE, 1);
        chk("hd_service", 16'h0031, last_svc);
        chk("hd_word", 16'hBEEF, last_hword);
        hd_res <= CTT_RES_OK;
        rcv(CTT_KIND_VSC, CTT_RES_OK, 1);
        chk("fault", 16'h0000, 16'(fault_status));
        hd_mute <= 1'b1;
        rcv(CTT_KIND_VSC, CTT_RES_OK, 1);
        chk("fault", 16'h0001, 16'(fault_status));
        $display("test receive done");
    endtask
    task automatic t_fault();
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        hd_mute <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("fault", 16'h0000, 16'(fault_status));
        regi(CTT_KIND_VSC, 16'h0021, 1'b1);
        hd_res <= CTT_RES_GENERAL_FAILURE;
        rcv(CTT_KIND_VSC, CTT_RES_OK, 1);
        hd_res <= CTT_RES_OK;
        rcv(CTT_KIND_VSC, CTT_RES_OK, 1);
        chk("fault", 16'h0001, 16'(fault_status));
        $display("test fault done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_freeze();
        t_send();
        t_bcast();
        t_recv();
        t_fault();
        close_out();
    end
    // All tests need well under a thousand cycles; this margin only cuts a hang
    initial begin
        repeat (6000) @(posedge sys_clk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        close_out();
    end
endmodule
`default_nettype wire
